// *** hdl/scs_pkg.sv ***
package scs_pkg;
    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [11:0] OSC_CTL_ADDR = 12'hf86;
    localparam logic [11:0] OSC_STAT_ADDR = 12'hf8f;
    localparam logic [7:0] OSC_CTL_RESET = 8'ha0;
    localparam logic [7:0] UNLOCK_FIRST = 8'he7;
    localparam logic [7:0] UNLOCK_SECOND = 8'h18;
    localparam logic [7:0] CTL_WR_MASK = 8'hbf;
    localparam int B_RC_EN = 7;
    localparam int B_WDT_EN = 5;
    localparam int B_PRI_FEN = 4;
    localparam int B_WDT_FEN = 3;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 3;
    // ------------------------------------------------------------
    // source codes
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_RC_FAST = 3'h0;
    localparam logic [2:0] SRC_RC_SLOW = 3'h1;
    localparam logic [2:0] SRC_WDT = 3'h3;
    localparam logic [2:0] SRC_EXT = 3'h4;
    // ------------------------------------------------------------
    // detector timing
    // ------------------------------------------------------------
    localparam int PRI_FAIL_HZ = 1000;
    localparam int WDT_NOM_HZ = 10000;
    localparam int PRI_FAIL_EDGES = WDT_NOM_HZ / PRI_FAIL_HZ;
    localparam int WDT_FAIL_CYCLES = 8004;
    localparam int WCNT_W = 14;
    localparam int PCNT_W = 4;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LK_LOCKED = 3'h1,
        LK_HALF = 3'h2,
        LK_OPEN = 3'h4
    } scs_lock_t;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scs_bus_t;
endpackage : scs_pkg

// *** hdl/scs_top.sv ***
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module scs_top #(
    parameter int WDT_FAIL_CYCLES = scs_pkg::WDT_FAIL_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire scs_pkg::scs_bus_t bus_i,
    input wire logic wdt_osc_i,
    input wire logic pri_osc_i,
    output logic [7:0] rdata_o,
    output logic [2:0] sys_src_o,
    output logic rc_en_o,
    output logic wdt_en_o,
    output logic pri_fail_evt_o,
    output logic wdt_fail_evt_o,
    output logic halted_o
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic sel_legal(input logic [2:0] s);
        sel_legal = (s == scs_pkg::SRC_RC_FAST) || (s == scs_pkg::SRC_RC_SLOW)
                 || (s == scs_pkg::SRC_WDT) || (s == scs_pkg::SRC_EXT);
    endfunction : sel_legal

    function automatic logic src_dead(input logic [2:0] s, input logic [7:0] c);
        src_dead = ((s == scs_pkg::SRC_RC_FAST || s == scs_pkg::SRC_RC_SLOW)
                    && !c[scs_pkg::B_RC_EN])
                || (s == scs_pkg::SRC_WDT && !c[scs_pkg::B_WDT_EN]);
    endfunction : src_dead

    scs_pkg::scs_lock_t lock_reg, lock_next;
    logic [7:0] ctl_reg, ctl_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [2:0] src_reg, src_next;
    logic [2:0] legal_sel_reg;
    logic force_reg, force_next;
    logic wdt_dead_reg, wdt_dead_next;
    logic pri_seen_reg, pri_seen_next;
    logic halted_reg, halted_next;
    logic pri_evt_reg, wdt_evt_reg;
    logic [1:0] sync1_reg, sync2_reg, sync3_reg;
    logic [scs_pkg::WCNT_W-1:0] wcnt_reg, wcnt_next;
    logic [scs_pkg::PCNT_W-1:0] pcnt_reg, pcnt_next;

    wire ctl_hit = bus_i.addr == scs_pkg::OSC_CTL_ADDR;
    wire stat_hit = bus_i.addr == scs_pkg::OSC_STAT_ADDR;
    wire ctl_wr = bus_i.wr && ctl_hit;
    wire data_wr = ctl_wr && (lock_reg == scs_pkg::LK_OPEN);
    wire [7:0] ctl_wval = bus_i.wdata & scs_pkg::CTL_WR_MASK;
    wire [2:0] cur_sel = ctl_reg[scs_pkg::SEL_LSB +: scs_pkg::SEL_W];
    wire pri_fen = ctl_reg[scs_pkg::B_PRI_FEN];
    wire wdt_fen = ctl_reg[scs_pkg::B_WDT_FEN];
    wire wdt_on = ctl_reg[scs_pkg::B_WDT_EN];
    wire wdt_edge = sync2_reg[0] && !sync3_reg[0];
    wire pri_edge = sync2_reg[1] && !sync3_reg[1];

    // ------------------------------------------------------------
    // unlock sequencer
    // ------------------------------------------------------------
    // only control register writes move the sequencer; reads and other
    // addresses leave it where it is, so the pair may be split up
    always_comb begin
        lock_next = lock_reg;
        if (ctl_wr) begin
            unique case (lock_reg)
                scs_pkg::LK_LOCKED: begin
                    if (bus_i.wdata == scs_pkg::UNLOCK_FIRST) begin
                        lock_next = scs_pkg::LK_HALF;
                    end
                end
                scs_pkg::LK_HALF: begin
                    if (bus_i.wdata == scs_pkg::UNLOCK_SECOND) begin
                        lock_next = scs_pkg::LK_OPEN;
                    end else if (bus_i.wdata != scs_pkg::UNLOCK_FIRST) begin
                        lock_next = scs_pkg::LK_LOCKED;
                    end
                end
                scs_pkg::LK_OPEN: begin
                    lock_next = scs_pkg::LK_LOCKED;
                end
                default: begin
                    lock_next = scs_pkg::LK_LOCKED;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // stored bits change only on the write that follows the unlock pair;
    // a new select write also loads the rc enable from the same byte
    always_comb begin
        ctl_next = ctl_reg;
        if (data_wr) begin
            ctl_next = ctl_wval;
        end
    end

    // ------------------------------------------------------------
    // watchdog oscillator failure detector
    // ------------------------------------------------------------
    // counts system cycles between watchdog edges; a very slow system
    // clock makes this detection slow as well
    localparam int WCNT_W = scs_pkg::WCNT_W;
    always_comb begin
        wcnt_next = wcnt_reg;
        wdt_dead_next = wdt_dead_reg;
        if (!wdt_fen || wdt_edge || wdt_dead_reg) begin
            wcnt_next = '0;
        end else if (wcnt_reg == WCNT_W'(WDT_FAIL_CYCLES - 1)) begin
            wcnt_next = '0;
            wdt_dead_next = 1'b1;
        end else begin
            wcnt_next = wcnt_reg + WCNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // primary oscillator failure detector
    // ------------------------------------------------------------
    // the watchdog oscillator is the reference: ten of its edges with no
    // primary edge means the primary runs below the threshold
    localparam int PCNT_W = scs_pkg::PCNT_W;
    wire pri_armed = pri_fen && !wdt_dead_reg;
    wire pri_trip = pri_armed && wdt_edge && !pri_edge
                 && pcnt_reg == PCNT_W'(scs_pkg::PRI_FAIL_EDGES - 1);
    always_comb begin
        pcnt_next = pcnt_reg;
        pri_seen_next = pri_seen_reg && pri_fen;
        if (!pri_armed || pri_edge) begin
            pcnt_next = '0;
        end else if (pri_trip) begin
            pcnt_next = '0;
            pri_seen_next = 1'b1;
        end else if (wdt_edge) begin
            pcnt_next = pcnt_reg + PCNT_W'(1);
        end
    end
    wire pri_event = pri_trip && !pri_seen_reg;

    // ------------------------------------------------------------
    // fallback and source steering
    // ------------------------------------------------------------
    // fallback holds until software writes the register again
    wire fall_ok = cur_sel != scs_pkg::SRC_WDT && wdt_on;
    always_comb begin
        force_next = force_reg;
        if (data_wr) begin
            force_next = 1'b0;
        end
        if (pri_event && fall_ok) begin
            force_next = 1'b1;
        end
    end

    // a reserved select code keeps the last legal source running
    wire [2:0] sel_eff = sel_legal(cur_sel) ? cur_sel : legal_sel_reg;
    assign src_next = force_reg ? scs_pkg::SRC_WDT : sel_eff;

    // a dead source with nothing to fall back to stops the chip; only
    // the power-on reset clears this
    assign halted_next = halted_reg
                      || (src_dead(src_reg, ctl_reg) && !force_reg);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    wire [7:0] stat_word = {1'b0, halted_reg, pri_seen_reg, wdt_dead_reg,
                            force_reg, lock_reg};
    always_comb begin
        rdata_next = rdata_reg;
        if (bus_i.rd) begin
            rdata_next = '0;
            if (ctl_hit) begin
                rdata_next = ctl_reg & scs_pkg::CTL_WR_MASK;
            end else if (stat_hit) begin
                rdata_next = stat_word;
            end
        end else begin
            rdata_next = '0;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // bit 0 watchdog oscillator, bit 1 primary oscillator
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= {pri_osc_i, wdt_osc_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_reg <= scs_pkg::LK_LOCKED;
            ctl_reg <= scs_pkg::OSC_CTL_RESET;
            rdata_reg <= '0;
            legal_sel_reg <= scs_pkg::SRC_RC_FAST;
            src_reg <= scs_pkg::SRC_RC_FAST;
            force_reg <= 1'b0;
            halted_reg <= 1'b0;
        end else begin
            lock_reg <= lock_next;
            ctl_reg <= ctl_next;
            rdata_reg <= rdata_next;
            legal_sel_reg <= sel_eff;
            src_reg <= src_next;
            force_reg <= force_next;
            halted_reg <= halted_next;
        end
    end

    // detector state and one-cycle failure events
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wcnt_reg <= '0;
            pcnt_reg <= '0;
            wdt_dead_reg <= 1'b0;
            pri_seen_reg <= 1'b0;
            pri_evt_reg <= 1'b0;
            wdt_evt_reg <= 1'b0;
        end else begin
            wcnt_reg <= wcnt_next;
            pcnt_reg <= pcnt_next;
            wdt_dead_reg <= wdt_dead_next;
            pri_seen_reg <= pri_seen_next;
            pri_evt_reg <= pri_event;
            wdt_evt_reg <= wdt_dead_next && !wdt_dead_reg;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata_o = rdata_reg;
    assign sys_src_o = src_reg;
    assign rc_en_o = ctl_reg[scs_pkg::B_RC_EN];
    assign wdt_en_o = ctl_reg[scs_pkg::B_WDT_EN];
    assign pri_fail_evt_o = pri_evt_reg;
    assign wdt_fail_evt_o = wdt_evt_reg;
    assign halted_o = halted_reg;
endmodule : scs_top
`default_nettype wire

// *** dv/scs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// --------
// port checker
// --------
module scs_properties #(
    parameter int WDT_FAIL_CYCLES = 8004
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire scs_pkg::scs_bus_t bus_i,
    input wire logic wdt_osc_i,
    input wire logic pri_osc_i,
    input wire logic [7:0] rdata_o,
    input wire logic [2:0] sys_src_o,
    input wire logic rc_en_o,
    input wire logic wdt_en_o,
    input wire logic pri_fail_evt_o,
    input wire logic wdt_fail_evt_o,
    input wire logic halted_o
);
    logic ctl_wr;
    logic ctl_rd;
    logic pin_reg;
    logic dead_reg;
    logic [15:0] quiet_reg;
    // control register strobes
    assign ctl_wr = bus_i.wr && (bus_i.addr == scs_pkg::OSC_CTL_ADDR);
    assign ctl_rd = bus_i.rd && (bus_i.addr == scs_pkg::OSC_CTL_ADDR);
    // quiet time of the pin; saturates so a stuck pin never wraps to zero
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_reg <= 1'b0;
            quiet_reg <= 16'h0000;
            dead_reg <= 1'b0;
        end else begin
            pin_reg <= wdt_osc_i;
            quiet_reg <= (wdt_osc_i != pin_reg) ? 16'h0000 : quiet_reg + {15'h0000, ~&quiet_reg};
            dead_reg <= dead_reg | wdt_fail_evt_o;
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);
    a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not idle");
    a_rsvd_bit_zero: assert property ($past(ctl_rd) |-> !rdata_o[6])
        else $error("reserved bit read as one");
    a_ctl_hold: assert property ($changed(rc_en_o) || $changed(wdt_en_o) |->
        $past(ctl_wr) || $past(ctl_wr, 2)) else $error("enable moved without write");
    a_wdt_evt_pulse: assert property (wdt_fail_evt_o |=>
        !wdt_fail_evt_o && $stable(sys_src_o)) else $error("watchdog event wrong");
    a_wdt_evt_quiet: assert property (wdt_fail_evt_o |->
        quiet_reg >= WDT_FAIL_CYCLES - 1) else $error("watchdog event too early");
    a_fallback_taken: assert property (pri_fail_evt_o && wdt_en_o &&
        sys_src_o != scs_pkg::SRC_WDT |-> ##[1:2] sys_src_o == scs_pkg::SRC_WDT)
        else $error("no fallback to watchdog clock");
    a_no_fallback: assert property (pri_fail_evt_o && !wdt_en_o |=>
        $stable(sys_src_o) [*3]) else $error("fallback while disabled");
    a_pri_dead: assert property (dead_reg |-> !pri_fail_evt_o)
        else $error("primary event after watchdog death");
endmodule : scs_properties
bind scs_top scs_properties #(.WDT_FAIL_CYCLES(WDT_FAIL_CYCLES)) i_scs_properties (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus_i(bus_i), .wdt_osc_i(wdt_osc_i),
    .pri_osc_i(pri_osc_i), .rdata_o(rdata_o), .sys_src_o(sys_src_o), .rc_en_o(rc_en_o),
    .wdt_en_o(wdt_en_o), .pri_fail_evt_o(pri_fail_evt_o), .wdt_fail_evt_o(wdt_fail_evt_o),
    .halted_o(halted_o));
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int FAIL_CYC = 40;
    localparam logic [11:0] CTL = scs_pkg::OSC_CTL_ADDR;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    scs_pkg::scs_bus_t bus = '0;
    logic osc_w = 1'b0;
    logic osc_p = 1'b0;
    logic [7:0] rdata;
    logic [2:0] src;
    logic rc_en;
    logic wd_en;
    logic halted;
    logic pri_evt;
    logic wd_evt;
    int err_count = 0;
    int compares = 0;
    int pri_n = 0;
    int n;
    logic [2:0] sel [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h2};
    logic [7:0] cfg [4] = '{8'hb0, 8'hb0, 8'h90, 8'hb3};
    logic [7:0] exp_src [4] = '{8'h00, 8'h03, 8'h00, 8'h03};
    logic [7:0] exp_evt [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
    scs_top #(.WDT_FAIL_CYCLES(FAIL_CYC)) i_scs_top (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .bus_i(bus), .wdt_osc_i(osc_w), .pri_osc_i(osc_p),
        .rdata_o(rdata), .sys_src_o(src), .rc_en_o(rc_en), .wdt_en_o(wd_en),
        .pri_fail_evt_o(pri_evt), .wdt_fail_evt_o(wd_evt), .halted_o(halted));
    // --------
    // clock and event counting
    // --------
    always #12.5 clk_sys_i = ~clk_sys_i;
    // pulses last one cycle, so count them rather than poll
    always @(posedge clk_sys_i) begin
        if (pri_evt === 1'b1) pri_n++;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one idle cycle after each access keeps strobes from being rewritten in one step
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
        #1 chk(nm, exp, rdata);
        @(posedge clk_sys_i);
    endtask : rd
    task automatic unl_wr(input logic [7:0] d);
        wr(CTL, 8'he7);
        wr(CTL, 8'h18);
        wr(CTL, d);
    endtask : unl_wr
    // watchdog pin toggles every 4 cycles; primary pin optionally alongside
    task automatic tog(input int k, input logic p);
        repeat (k) begin
            repeat (4) @(posedge clk_sys_i);
            osc_w <= ~osc_w;
            osc_p <= osc_p ^ p;
        end
    endtask : tog
    task automatic do_reset;
        resetn_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
    endtask : do_reset
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    // --------
    // main sequence
    // --------
    initial begin
        do_reset;
        rd(CTL, scs_pkg::OSC_CTL_RESET, "ctl reset");
        chk("rc enable", 8'h01, {7'h00, rc_en});
        wr(CTL, 8'h03);
        wr(CTL, 8'h18);
        wr(CTL, 8'he7);
        wr(CTL, 8'h01);
        rd(CTL, 8'ha0, "ctl locked");
        wr(CTL, 8'he7);
        rd(CTL, 8'ha0, "ctl mid unlock");
        wr(12'h100, 8'h55);
        wr(CTL, 8'h18);
        wr(CTL, 8'hc1);
        rd(CTL, 8'h81, "ctl written");
        rd(12'h100, 8'h00, "unmapped");
        wr(CTL, 8'ha0);
        rd(CTL, 8'h81, "ctl relocked");
        for (int i = 0; i < 5; i++) begin
            unl_wr(8'ha0 | {5'h00, sel[i]});
            rd(CTL, 8'ha0 | {5'h00, sel[i]}, "ctl select");
            chk("source", {5'h00, (sel[i] == 3'h2) ? 3'h4 : sel[i]}, {5'h00, src});
            chk("rc kept", 8'h01, {7'h00, rc_en});
        end
        unl_wr(8'ha8);
        for (n = 0; n < 200 && wd_evt !== 1'b1; n++) @(negedge clk_sys_i);
        chk("dog delay", 8'h01, {7'h00, n >= FAIL_CYC && n <= FAIL_CYC + 8});
        chk("source kept", 8'h00, {5'h00, src});
        rd(scs_pkg::OSC_STAT_ADDR, 8'h11, "status dead");
        unl_wr(8'hb0);
        tog(24, 1'b0);
        chk("primary dead", 8'h00, 8'(pri_n));
        for (int i = 0; i < 4; i++) begin
            do_reset;
            pri_n = 0;
            unl_wr(cfg[i]);
            tog(24, i == 0);
            repeat (4) @(negedge clk_sys_i);
            chk("primary events", exp_evt[i], 8'(pri_n));
            chk("fallback source", exp_src[i], {5'h00, src});
        end
        // rc selected but switched off, nothing to fall back to
        do_reset;
        chk("wdt enable", 8'h01, {7'h00, wd_en});
        unl_wr(8'h20);
        repeat (2) @(negedge clk_sys_i);
        chk("halted", 8'h01, {7'h00, halted});
        close_out;
    end
    // hang guard, well beyond the roughly 700 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        close_out;
    end
endmodule : tb
`default_nettype wire
